// >>> rtl/apifr_regs.v
// What this block does
// RULE1: With link and auto-sleep set, inactivity puts the device asleep; otherwise never automatic.
// RULE2: Host should go to standby before returning to measurement after clearing sleep bits.
// RULE3: Measure bit 0 is standby, 1 is measurement; reset leaves standby.
// RULE4: Asleep suppresses data-ready, stops queue writes, samples at the sleep rate.
// RULE5: Asleep keeps only activity detection running; other detectors stay off.
// RULE6: Sleep rate code 00..11 gives 8, 4, 2, 1 readings per second.
// RULE7: Each enable bit at 1 passes its event to an interrupt pin; 0 blocks.
// RULE8: Enables for data-ready, watermark, overrun gate only the pin, never the flag.
// RULE9: Host should configure each interrupt function before enabling it.
// RULE10: Route bit 0 steers an event to pin A, 1 to pin B.
// RULE11: Each pin is the OR of enabled events routed to it.
// RULE12: Flags show 1 for occurred events; data flags set regardless of enables.
// RULE13: Data-ready, watermark, overrun clear only through axis data reads, maybe several.
// RULE14: Other flags, orientation included, clear when the flag register is read.
// RULE15: Self-test bit 1 applies the test force; 0 removes it.
// RULE16: Wire-mode bit 1 selects 3-wire serial, 0 selects 4-wire.
// RULE17: Polarity bit 0 makes both pins active high, 1 active low.
// RULE18: Wide resolution keeps 4 mg/LSB growing width; otherwise 10-bit scaled by range.
// RULE19: Justify bit 1 left-justifies; 0 right-justifies with sign extension.
// RULE20: Range code 00..11 selects 2, 4, 8, 16 g full scale.
// RULE21: Six read-only bytes hold x, y, z low then high, twos complement.
// RULE22: Host should read all six axis bytes in one burst.
// RULE23: Queue mode field: bypass, fill-then-stop, keep latest, trigger capture.
// RULE24: With link, activity waits for inactivity, inactivity resumes after activity.
`timescale 1ns/100ps
`include "apifr_defs.vh"

module apifr_regs
#(
    parameter [24:0] SLEEP_BASE_CYC = `APIFR_CLK_HZ / `APIFR_SLEEP_BASE_HZ
)
(
    // Clock and reset
    input wire clk_i,
    input wire nrst_i,
    // Register port from the serial front end, same clock
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [7:0] reg_rdata_o,
    // Detector and queue events, one-cycle pulses
    input wire evt_data_ready_i,
    input wire evt_single_tap_i,
    input wire evt_double_tap_i,
    input wire evt_activity_i,
    input wire evt_inactivity_i,
    input wire evt_free_fall_i,
    input wire evt_watermark_i,
    input wire evt_overrun_i,
    input wire evt_orient_i,
    // Queue state levels and orientation selection
    input wire data_pending_i,
    input wire watermark_level_i,
    input wire orient_sel_i,
    // Raw sample, 13-bit signed at 4 mg/LSB
    input wire sample_valid_i,
    input wire [12:0] sample_x_i,
    input wire [12:0] sample_y_i,
    input wire [12:0] sample_z_i,
    // Power and detector control
    output reg measure_o,
    output reg asleep_o,
    output reg sleep_tick_o,
    output reg queue_write_en_o,
    output reg act_detect_en_o,
    output reg inact_detect_en_o,
    output reg other_detect_en_o,
    // Format and serial control
    output reg self_test_o,
    output reg three_wire_o,
    // Queue control
    output reg [1:0] queue_mode_o,
    output reg queue_trig_pin_o,
    output reg [4:0] queue_samples_o,
    // Interrupt pins
    output reg irq_pin_a_o,
    output reg irq_pin_b_o
);

// ==========================================================
// Registers
reg [7:0] power_state_ctl_reg;
reg [7:0] irq_enable_reg;
reg [7:0] irq_pin_route_reg;
reg [7:0] irq_event_flags_reg;
reg [7:0] irq_event_flags_next;
reg [7:0] output_format_ctl_reg;
reg [7:0] queue_control_reg;
reg [15:0] x_data_reg;
reg [15:0] y_data_reg;
reg [15:0] z_data_reg;
reg auto_asleep_reg;
reg wait_act_reg;
reg [7:0] rdata_next;

wire link;
wire auto_sleep;
wire measure;
wire asleep;
wire wr_power;
wire rd_flags;
wire rd_data;
wire [7:0] evt;
wire [7:0] clr;
wire [7:0] pin_a_hits;
wire [7:0] pin_b_hits;
wire sleep_tick;

assign link = power_state_ctl_reg[`APIFR_PWR_LINK];
assign auto_sleep = power_state_ctl_reg[`APIFR_PWR_AUTO_SLEEP];
assign measure = power_state_ctl_reg[`APIFR_PWR_MEASURE]; // RULE3
assign asleep = power_state_ctl_reg[`APIFR_PWR_SLEEP] | auto_asleep_reg;
assign wr_power = reg_wr_i && (reg_addr_i == `APIFR_OFF_POWER);
assign rd_flags = reg_rd_i && (reg_addr_i == `APIFR_OFF_IRQ_FLAGS);
assign rd_data = reg_rd_i && (reg_addr_i >= `APIFR_OFF_X_LOW) && (reg_addr_i <= `APIFR_OFF_Z_HIGH);

// ==========================================================
// Sample formatting
reg [15:0] fmt_x;
reg [15:0] fmt_y;
reg [15:0] fmt_z;

// Clip to the selected width, then place right or left; clipping avoids rollover
function [15:0] apifr_fmt;
    input [12:0] raw;
    input wide;
    input left;
    input [1:0] range;
    reg signed [12:0] v;
    reg signed [12:0] hi;
    reg signed [12:0] lo;
    reg [4:0] w;
    reg [15:0] ext;
    begin
        if (wide)
        begin
            w = 5'd10 + {3'b000, range}; // RULE18
            v = $signed(raw);
        end
        else
        begin
            w = 5'd10; // RULE18
            v = $signed(raw) >>> range; // RULE20
        end
        hi = $signed(13'h1fff >> (5'd14 - w));
        lo = ~hi;
        if (v > hi)
            v = hi;
        if (v < lo)
            v = lo;
        ext = {{3{v[12]}}, v};
        if (left)
            apifr_fmt = ext << (5'd16 - w); // RULE19
        else
            apifr_fmt = ext; // RULE19
    end
endfunction

always @*
begin
    fmt_x = apifr_fmt(sample_x_i, output_format_ctl_reg[`APIFR_FMT_WIDE_RES],
        output_format_ctl_reg[`APIFR_FMT_JUSTIFY],
        output_format_ctl_reg[`APIFR_FMT_RANGE_HI:`APIFR_FMT_RANGE_LO]);
    fmt_y = apifr_fmt(sample_y_i, output_format_ctl_reg[`APIFR_FMT_WIDE_RES],
        output_format_ctl_reg[`APIFR_FMT_JUSTIFY],
        output_format_ctl_reg[`APIFR_FMT_RANGE_HI:`APIFR_FMT_RANGE_LO]);
    fmt_z = apifr_fmt(sample_z_i, output_format_ctl_reg[`APIFR_FMT_WIDE_RES],
        output_format_ctl_reg[`APIFR_FMT_JUSTIFY],
        output_format_ctl_reg[`APIFR_FMT_RANGE_HI:`APIFR_FMT_RANGE_LO]);
end

// ==========================================================
// Event collection and flag clearing
// Bit 0 carries orientation instead of overrun while orientation is selected
assign evt[`APIFR_EV_DATA_READY] = evt_data_ready_i & ~asleep; // RULE4
assign evt[`APIFR_EV_SINGLE_TAP] = evt_single_tap_i;
assign evt[`APIFR_EV_DOUBLE_TAP] = evt_double_tap_i;
assign evt[`APIFR_EV_ACTIVITY] = evt_activity_i;
assign evt[`APIFR_EV_INACTIVITY] = evt_inactivity_i;
assign evt[`APIFR_EV_FREE_FALL] = evt_free_fall_i;
assign evt[`APIFR_EV_WATERMARK] = evt_watermark_i; // RULE12
assign evt[`APIFR_EV_OVERRUN] = orient_sel_i ? evt_orient_i : evt_overrun_i;

// Data-ready falls only once a data read leaves nothing pending, watermark once a data read leaves the watermark level low; overrun falls on any data read
assign clr[`APIFR_EV_DATA_READY] = rd_data & ~data_pending_i; // RULE13
assign clr[`APIFR_EV_WATERMARK] = rd_data & ~watermark_level_i; // RULE13
assign clr[`APIFR_EV_SINGLE_TAP] = rd_flags; // RULE14
assign clr[`APIFR_EV_DOUBLE_TAP] = rd_flags;
assign clr[`APIFR_EV_ACTIVITY] = rd_flags;
assign clr[`APIFR_EV_INACTIVITY] = rd_flags;
assign clr[`APIFR_EV_FREE_FALL] = rd_flags;
// Orientation also drops when the part goes to standby
assign clr[`APIFR_EV_OVERRUN] = orient_sel_i ? (rd_flags | ~measure) : rd_data; // RULE14

// Set wins over clear so an event in the read cycle is kept
always @*
begin
    irq_event_flags_next = (irq_event_flags_reg & ~clr) | evt; // RULE12
end

// ==========================================================
// Interrupt pin steering
assign pin_a_hits = irq_event_flags_reg & irq_enable_reg & ~irq_pin_route_reg; // RULE7 RULE10
assign pin_b_hits = irq_event_flags_reg & irq_enable_reg & irq_pin_route_reg; // RULE8 RULE10

// ==========================================================
// Register writes
always @(posedge clk_i or negedge nrst_i)
begin
    if (!nrst_i)
    begin
        power_state_ctl_reg <= `APIFR_RST_POWER; // RULE3
        irq_enable_reg <= `APIFR_RST_IRQ_EN;
        irq_pin_route_reg <= `APIFR_RST_IRQ_ROUTE;
        output_format_ctl_reg <= `APIFR_RST_FORMAT;
        queue_control_reg <= `APIFR_RST_QUEUE;
    end
    else if (reg_wr_i)
    begin
        case (reg_addr_i)
            `APIFR_OFF_POWER: power_state_ctl_reg <= {2'b00, reg_wdata_i[5:0]};
            `APIFR_OFF_IRQ_EN: irq_enable_reg <= reg_wdata_i;
            `APIFR_OFF_IRQ_ROUTE: irq_pin_route_reg <= reg_wdata_i;
            `APIFR_OFF_FORMAT: output_format_ctl_reg <= {reg_wdata_i[7:5], 1'b0, reg_wdata_i[3:0]};
            `APIFR_OFF_QUEUE: queue_control_reg <= reg_wdata_i;
            default: power_state_ctl_reg <= power_state_ctl_reg;
        endcase
    end
end

// ==========================================================
// Flags, sleep state and link sequencing
// A write to the power register drops automatic sleep so software regains control
always @(posedge clk_i or negedge nrst_i)
begin
    if (!nrst_i)
    begin
        irq_event_flags_reg <= 8'h00;
        auto_asleep_reg <= 1'b0;
        wait_act_reg <= 1'b0;
    end
    else
    begin
        irq_event_flags_reg <= irq_event_flags_next;
        if (wr_power || !measure || !link || !auto_sleep)
            auto_asleep_reg <= 1'b0; // RULE1
        else if (evt_activity_i)
            auto_asleep_reg <= 1'b0;
        else if (evt_inactivity_i)
            auto_asleep_reg <= 1'b1; // RULE1
        if (!link || !measure)
            wait_act_reg <= 1'b0;
        else if (evt_inactivity_i)
            wait_act_reg <= 1'b1; // RULE24
        else if (evt_activity_i)
            wait_act_reg <= 1'b0; // RULE24
    end
end

// ==========================================================
// Axis data snapshot
// All six bytes load together in one cycle, so no single load leaves them holding two samples
always @(posedge clk_i or negedge nrst_i)
begin
    if (!nrst_i)
    begin
        x_data_reg <= 16'h0000;
        y_data_reg <= 16'h0000;
        z_data_reg <= 16'h0000;
    end
    else if (sample_valid_i && measure)
    begin
        x_data_reg <= fmt_x; // RULE21
        y_data_reg <= fmt_y;
        z_data_reg <= fmt_z;
    end
end

// ==========================================================
// Read data mux
always @*
begin
    case (reg_addr_i)
        `APIFR_OFF_POWER: rdata_next = power_state_ctl_reg;
        `APIFR_OFF_IRQ_EN: rdata_next = irq_enable_reg;
        `APIFR_OFF_IRQ_ROUTE: rdata_next = irq_pin_route_reg;
        `APIFR_OFF_IRQ_FLAGS: rdata_next = irq_event_flags_reg;
        `APIFR_OFF_FORMAT: rdata_next = output_format_ctl_reg;
        `APIFR_OFF_X_LOW: rdata_next = x_data_reg[7:0]; // RULE21
        `APIFR_OFF_X_HIGH: rdata_next = x_data_reg[15:8];
        `APIFR_OFF_Y_LOW: rdata_next = y_data_reg[7:0];
        `APIFR_OFF_Y_HIGH: rdata_next = y_data_reg[15:8];
        `APIFR_OFF_Z_LOW: rdata_next = z_data_reg[7:0];
        `APIFR_OFF_Z_HIGH: rdata_next = z_data_reg[15:8];
        `APIFR_OFF_QUEUE: rdata_next = queue_control_reg;
        default: rdata_next = 8'h00;
    endcase
end

// Read data holds until the next read
always @(posedge clk_i or negedge nrst_i)
begin
    if (!nrst_i)
        reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
        reg_rdata_o <= rdata_next;
end

// ==========================================================
// Sleep reading rate
apifr_sleep_tick
#(
    .BASE_CYC(SLEEP_BASE_CYC)
)
u_sleep_tick
(
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .run_i(measure & asleep),
    .rate_i(power_state_ctl_reg[`APIFR_PWR_RATE_HI:`APIFR_PWR_RATE_LO]),
    .tick_o(sleep_tick)
);

// ==========================================================
// Registered outputs
// One cycle behind the control registers; detectors tolerate that lag
always @(posedge clk_i or negedge nrst_i)
begin
    if (!nrst_i)
    begin
        measure_o <= 1'b0;
        asleep_o <= 1'b0;
        sleep_tick_o <= 1'b0;
        queue_write_en_o <= 1'b0;
        act_detect_en_o <= 1'b0;
        inact_detect_en_o <= 1'b0;
        other_detect_en_o <= 1'b0;
        self_test_o <= 1'b0;
        three_wire_o <= 1'b0;
        queue_mode_o <= 2'b00;
        queue_trig_pin_o <= 1'b0;
        queue_samples_o <= 5'h00;
        irq_pin_a_o <= 1'b0;
        irq_pin_b_o <= 1'b0;
    end
    else
    begin
        measure_o <= measure; // RULE3
        asleep_o <= asleep;
        sleep_tick_o <= sleep_tick; // RULE4
        queue_write_en_o <= measure & ~asleep; // RULE4
        act_detect_en_o <= measure & (~link | wait_act_reg); // RULE5 RULE24
        inact_detect_en_o <= measure & ~asleep & (~link | ~wait_act_reg); // RULE5 RULE24
        other_detect_en_o <= measure & ~asleep; // RULE5
        self_test_o <= output_format_ctl_reg[`APIFR_FMT_SELF_TEST]; // RULE15
        three_wire_o <= output_format_ctl_reg[`APIFR_FMT_THREE_WIRE]; // RULE16
        queue_mode_o <= queue_control_reg[`APIFR_Q_MODE_HI:`APIFR_Q_MODE_LO]; // RULE23
        queue_trig_pin_o <= queue_control_reg[`APIFR_Q_TRIG_PIN];
        queue_samples_o <= queue_control_reg[`APIFR_Q_SAMPLES_HI:`APIFR_Q_SAMPLES_LO];
        irq_pin_a_o <= (|pin_a_hits) ^ output_format_ctl_reg[`APIFR_FMT_IRQ_INVERT]; // RULE11 RULE17
        irq_pin_b_o <= (|pin_b_hits) ^ output_format_ctl_reg[`APIFR_FMT_IRQ_INVERT]; // RULE11 RULE17
    end
end

endmodule // apifr_regs

// >>> rtl/apifr_defs.vh
`ifndef APIFR_DEFS_VH
`define APIFR_DEFS_VH

// ==========================================================
// Register offsets
`define APIFR_OFF_POWER 8'h2d
`define APIFR_OFF_IRQ_EN 8'h2e
`define APIFR_OFF_IRQ_ROUTE 8'h2f
`define APIFR_OFF_IRQ_FLAGS 8'h30
`define APIFR_OFF_FORMAT 8'h31
`define APIFR_OFF_X_LOW 8'h32
`define APIFR_OFF_X_HIGH 8'h33
`define APIFR_OFF_Y_LOW 8'h34
`define APIFR_OFF_Y_HIGH 8'h35
`define APIFR_OFF_Z_LOW 8'h36
`define APIFR_OFF_Z_HIGH 8'h37
`define APIFR_OFF_QUEUE 8'h38

// ==========================================================
// Reset values
`define APIFR_RST_POWER 8'h00
`define APIFR_RST_IRQ_EN 8'h00
`define APIFR_RST_IRQ_ROUTE 8'h00
`define APIFR_RST_FORMAT 8'h00
`define APIFR_RST_QUEUE 8'h00

// ==========================================================
// Power state control fields
`define APIFR_PWR_LINK 5
`define APIFR_PWR_AUTO_SLEEP 4
`define APIFR_PWR_MEASURE 3
`define APIFR_PWR_SLEEP 2
`define APIFR_PWR_RATE_HI 1
`define APIFR_PWR_RATE_LO 0

// ==========================================================
// Event bit positions, shared by enable, route and flags
`define APIFR_EV_DATA_READY 7
`define APIFR_EV_SINGLE_TAP 6
`define APIFR_EV_DOUBLE_TAP 5
`define APIFR_EV_ACTIVITY 4
`define APIFR_EV_INACTIVITY 3
`define APIFR_EV_FREE_FALL 2
`define APIFR_EV_WATERMARK 1
`define APIFR_EV_OVERRUN 0

// ==========================================================
// Output format fields
`define APIFR_FMT_SELF_TEST 7
`define APIFR_FMT_THREE_WIRE 6
`define APIFR_FMT_IRQ_INVERT 5
`define APIFR_FMT_WIDE_RES 3
`define APIFR_FMT_JUSTIFY 2
`define APIFR_FMT_RANGE_HI 1
`define APIFR_FMT_RANGE_LO 0

// ==========================================================
// Queue control fields
`define APIFR_Q_MODE_HI 7
`define APIFR_Q_MODE_LO 6
`define APIFR_Q_TRIG_PIN 5
`define APIFR_Q_SAMPLES_HI 4
`define APIFR_Q_SAMPLES_LO 0

// ==========================================================
// Timing: core clock and base sleep reading rate of code 00, the fastest
`define APIFR_CLK_HZ 20000000
`define APIFR_SLEEP_BASE_HZ 8

`endif

// >>> rtl/apifr_sleep_tick.v
`timescale 1ns/100ps
`include "apifr_defs.vh"

module apifr_sleep_tick
#(
    parameter [24:0] BASE_CYC = `APIFR_CLK_HZ / `APIFR_SLEEP_BASE_HZ
)
(
    // Clock and reset
    input wire clk_i,
    input wire nrst_i,
    // Control
    input wire run_i,
    input wire [1:0] rate_i,
    // Reading strobe
    output reg tick_o
);

// ==========================================================
// Period doubles per rate code: 8, 4, 2, 1 readings per second
wire [24:0] limit;
reg [24:0] cnt_reg;

assign limit = (BASE_CYC << rate_i) - 25'h0000001; // RULE6

// Counter restarts whenever sleep is left so the first reading is a full period away
always @(posedge clk_i or negedge nrst_i)
begin
    if (!nrst_i)
    begin
        cnt_reg <= 25'h0000000;
        tick_o <= 1'b0;
    end
    else if (!run_i)
    begin
        cnt_reg <= 25'h0000000;
        tick_o <= 1'b0;
    end
    else if (cnt_reg >= limit)
    begin
        cnt_reg <= 25'h0000000;
        tick_o <= 1'b1; // RULE6
    end
    else
    begin
        cnt_reg <= cnt_reg + 25'h0000001;
        tick_o <= 1'b0;
    end
end

endmodule // apifr_sleep_tick

// >>> verif/apifr_host_model.sv
`timescale 1ns/100ps
// ==========================================================
// Host side of the register port
module apifr_host_model (
    // Clock
    input wire clk_i,
    // Register port towards the block
    output reg [7:0] addr_o,
    output reg [7:0] wdata_o,
    output reg wr_o,
    output reg rd_o,
    input wire [7:0] rdata_i
);
    // Idle bus shows scrambled values so a stale address never looks valid
    initial
    begin
        addr_o = 8'hff;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // One byte write, held until the taking edge has passed
    task wr(input [7:0] a, input [7:0] v);
        begin
            @(posedge clk_i);
            #1;
            addr_o = a;
            wdata_o = v;
            wr_o = 1'b1;
            @(posedge clk_i);
            #1;
            wr_o = 1'b0;
            addr_o = ~a;
            wdata_o = ~v;
        end
    endtask

    // One byte read, data taken once the taking edge has loaded it
    task rd(input [7:0] a, output [7:0] d);
        begin
            @(posedge clk_i);
            #1;
            addr_o = a;
            rd_o = 1'b1;
            @(posedge clk_i);
            #1;
            d = rdata_i;
            rd_o = 1'b0;
            addr_o = ~a;
        end
    endtask
endmodule // apifr_host_model

// >>> verif/apifr_regs_props.sv
`timescale 1ns/100ps
// ==========================================================
// Port checker
module apifr_regs_props (
    // Clock and reset
    input wire clk_i,
    input wire nrst_i,
    // Register port
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_rdata_o,
    // Events
    input wire evt_single_tap_i,
    input wire evt_inactivity_i,
    // Watched outputs
    input wire measure_o,
    input wire asleep_o,
    input wire sleep_tick_o,
    input wire queue_write_en_o,
    input wire other_detect_en_o,
    input wire self_test_o,
    input wire [1:0] queue_mode_o,
    input wire irq_pin_b_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    reg [7:0] pwr_reg;
    reg [7:0] en_reg;
    reg [7:0] rt_reg;
    reg inv_reg;

    // Shadow of what the host wrote, so properties know the mode asked for
    always @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            pwr_reg <= 8'h00;
            en_reg <= 8'h00;
            rt_reg <= 8'h00;
            inv_reg <= 1'b0;
        end
        else if (reg_wr_i)
        begin
            if (reg_addr_i == 8'h2d)
                pwr_reg <= reg_wdata_i;
            if (reg_addr_i == 8'h2e)
                en_reg <= reg_wdata_i;
            if (reg_addr_i == 8'h2f)
                rt_reg <= reg_wdata_i;
            if (reg_addr_i == 8'h31)
                inv_reg <= reg_wdata_i[5];
        end
    end

    // ==========================================================
    // Sequences
    sequence pwr_write;
        reg_wr_i && reg_addr_i == 8'h2d;
    endsequence
    sequence fmt_write;
        reg_wr_i && reg_addr_i == 8'h31;
    endsequence
    sequence tap_to_b;
        evt_single_tap_i && en_reg[6] && rt_reg[6] && !inv_reg;
    endsequence

    // ==========================================================
    // Assertions
    chk_measure_bit:
        assert property (pwr_write |-> ##2 measure_o == $past(reg_wdata_i[3], 2))
        else $error("Measure output does not follow the power write");
    chk_self_test:
        assert property (fmt_write |-> ##2 self_test_o == $past(reg_wdata_i[7], 2))
        else $error("Self-test output does not follow the format write");
    chk_queue_mode:
        assert property (reg_wr_i && reg_addr_i == 8'h38
            |-> ##2 queue_mode_o == $past(reg_wdata_i[7:6], 2))
        else $error("Queue mode does not follow the queue write");
    chk_sleep_gate:
        assert property (asleep_o && $past(asleep_o) |-> !queue_write_en_o && !other_detect_en_o)
        else $error("Queue writes or detectors active while asleep");
    chk_tick_gap:
        assert property (sleep_tick_o |=> !sleep_tick_o [*8])
        else $error("Sleep readings closer than the fastest rate");
    chk_auto_sleep:
        assert property (evt_inactivity_i && pwr_reg[5:3] == 3'b111 |-> ##[1:2] asleep_o)
        else $error("Inactivity did not put the device asleep");
    chk_no_auto:
        assert property (!asleep_o && !pwr_reg[4] && !pwr_reg[2] |=> !asleep_o)
        else $error("Device fell asleep without auto or manual sleep");
    chk_pin_b_tap:
        assert property (tap_to_b |-> ##2 irq_pin_b_o)
        else $error("Routed tap did not raise the second pin");
    chk_unmapped_rd:
        assert property (reg_rd_i && reg_addr_i == 8'h3f |=> reg_rdata_o == 8'h00)
        else $error("Unmapped read returned nonzero data");
endmodule // apifr_regs_props

bind apifr_regs apifr_regs_props u_apifr_regs_props (
    .clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .evt_single_tap_i(evt_single_tap_i), .evt_inactivity_i(evt_inactivity_i),
    .measure_o(measure_o), .asleep_o(asleep_o), .sleep_tick_o(sleep_tick_o),
    .queue_write_en_o(queue_write_en_o), .other_detect_en_o(other_detect_en_o),
    .self_test_o(self_test_o), .queue_mode_o(queue_mode_o), .irq_pin_b_o(irq_pin_b_o)
);

// >>> verif/testbench.sv
`timescale 1ns/100ps
module testbench;
    // ==========================================================
    // Signals
    reg clk_i = 1'b0;
    reg nrst_i = 1'b0;
    reg [8:0] evt = 9'h000;
    reg pend = 1'b0;
    reg sv = 1'b0;
    reg [12:0] smp = 13'h0000;
    wire [7:0] addr, wdata, rdata;
    wire wr, rd, measure, asleep, tick, qwe, act_en, inact_en, oth_en, st, tw, qtp, pa, pb;
    wire [1:0] qm;
    wire [4:0] qs;
    integer n_mismatch = 0;
    integer cmp_count = 0;
    integer i, j, gap;
    reg [7:0] lo, hi;

    // 20 MHz clock
    always #25 clk_i = ~clk_i;

    // Short sleep base keeps the slowest reading rate at 128 cycles
    apifr_regs #(.SLEEP_BASE_CYC(25'd16)) u_apifr_regs (
        .clk_i(clk_i), .nrst_i(nrst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .evt_data_ready_i(evt[7]), .evt_single_tap_i(evt[6]), .evt_double_tap_i(evt[5]),
        .evt_activity_i(evt[4]), .evt_inactivity_i(evt[3]), .evt_free_fall_i(evt[2]),
        .evt_watermark_i(evt[1]), .evt_overrun_i(evt[0]), .evt_orient_i(evt[8]),
        .data_pending_i(pend), .watermark_level_i(pend), .orient_sel_i(1'b0),
        .sample_valid_i(sv), .sample_x_i(smp), .sample_y_i(smp), .sample_z_i(smp),
        .measure_o(measure), .asleep_o(asleep), .sleep_tick_o(tick), .queue_write_en_o(qwe),
        .act_detect_en_o(act_en), .inact_detect_en_o(inact_en), .other_detect_en_o(oth_en),
        .self_test_o(st), .three_wire_o(tw), .queue_mode_o(qm), .queue_trig_pin_o(qtp),
        .queue_samples_o(qs), .irq_pin_a_o(pa), .irq_pin_b_o(pb)
    );

    apifr_host_model u_apifr_host_model (
        .clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .rdata_i(rdata)
    );

    // ==========================================================
    // Helpers
    task check(input [15:0] got, input [15:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp)
            begin
                n_mismatch = n_mismatch + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task wreg(input [7:0] a, input [7:0] v);
        u_apifr_host_model.wr(a, v);
        step;
    endtask
    task rdchk(input [7:0] a, input [7:0] exp);
        begin
            u_apifr_host_model.rd(a, lo);
            check({8'h00, lo}, {8'h00, exp});
        end
    endtask
    task step;
        begin
            @(posedge clk_i);
            #1;
        end
    endtask
    // One-cycle event, returns after the pin has had its edge
    task pulse(input integer k);
        begin
            step;
            evt[k] = 1'b1;
            step;
            evt[k] = 1'b0;
            step;
        end
    endtask
    // Load one sample and fetch all six bytes in one pass
    task fmt_case(input [7:0] f, input [12:0] s, input [15:0] e);
        begin
            wreg(8'h31, f);
            smp = s;
            sv = 1'b1;
            step;
            sv = 1'b0;
            for (j = 0; j < 3; j = j + 1)
            begin
                u_apifr_host_model.rd(8'h32 + 2 * j, lo);
                u_apifr_host_model.rd(8'h33 + 2 * j, hi);
                check({hi, lo}, e);
            end
        end
    endtask
    // Cycles up to the next sleep reading, bounded
    task wait_tick(output integer n);
        begin
            n = 1;
            step;
            while (tick !== 1'b1 && n < 400)
            begin
                step;
                n = n + 1;
            end
        end
    endtask
    task wrap_up;
        begin
            $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
            if (n_mismatch == 0 && cmp_count > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask

    // ==========================================================
    // Tests
    initial
    begin
        repeat (16) @(posedge clk_i);
        #1;
        nrst_i = 1'b1;
        check(measure, 1'b0);
        for (i = 8'h2d; i < 8'h39; i = i + 1)
            rdchk(i[7:0], 8'h00);
        rdchk(8'h3f, 8'h00);
        wreg(8'h2d, 8'hc3);
        rdchk(8'h2d, 8'h03);
        wreg(8'h31, 8'hff);
        rdchk(8'h31, 8'hef);
        check({st, tw, pa, pb}, 4'hf);
        wreg(8'h31, 8'h00);
        check({st, tw, pa, pb}, 4'h0);
        wreg(8'h32, 8'h55);
        rdchk(8'h32, 8'h00);
        for (i = 0; i < 4; i = i + 1)
        begin
            wreg(8'h38, {i[1:0], 6'h21});
            check({qm, qtp, qs}, {i[1:0], 6'h21});
        end
        // Configure routing before the enable
        wreg(8'h2f, 8'h40);
        wreg(8'h2e, 8'h40);
        pulse(6);
        check({pa, pb}, 2'b01);
        rdchk(8'h30, 8'h40);
        step;
        check({pa, pb}, 2'b00);
        rdchk(8'h30, 8'h00);
        wreg(8'h2e, 8'h00);
        pulse(6);
        check({pa, pb}, 2'b00);
        u_apifr_host_model.rd(8'h30, lo);
        pulse(7);
        rdchk(8'h30, 8'h80);
        rdchk(8'h30, 8'h80);
        u_apifr_host_model.rd(8'h33, lo);
        rdchk(8'h30, 8'h00);
        wreg(8'h2e, 8'h80);
        pulse(7);
        check({pa, pb}, 2'b10);
        u_apifr_host_model.rd(8'h32, lo);
        step;
        check({pa, pb}, 2'b00);
        // Output formats while measuring
        wreg(8'h2d, 8'h08);
        fmt_case(8'h00, 13'h0300, 16'h01ff);
        fmt_case(8'h00, 13'h1c00, 16'hfe00);
        fmt_case(8'h04, 13'h0300, 16'h7fc0);
        fmt_case(8'h01, 13'h0300, 16'h0180);
        fmt_case(8'h0b, 13'h1234, 16'hf234);
        // Manual sleep at every reading rate
        for (i = 0; i < 4; i = i + 1)
        begin
            wreg(8'h2d, 8'h0c | i[7:0]);
            wait_tick(gap);
            wait_tick(gap);
            check(gap, 16 << i);
            check({asleep, qwe, oth_en, act_en}, 4'h9);
        end
        pulse(7);
        rdchk(8'h30, 8'h00);
        // Leave sleep through standby first
        wreg(8'h2d, 8'h00);
        wreg(8'h2d, 8'h08);
        check(asleep, 1'b0);
        wreg(8'h2d, 8'h38);
        pulse(3);
        step;
        check({asleep, act_en}, 2'b11);
        pulse(4);
        step;
        check({asleep, inact_en}, 2'b01);
        wreg(8'h2d, 8'h28);
        pulse(3);
        step;
        check(asleep, 1'b0);
        wrap_up;
    end

    // Watchdog: the sequence needs about 700 cycles
    initial
    begin
        #(20000 * 50);
        n_mismatch = n_mismatch + 1;
        wrap_up;
    end
endmodule // testbench
